// *** hw/rbc_top.sv ***
// Purpose: combine reset sources into core reset, keep cause flags
// Assumes: inputs synchronous enough to pass a two-stage synchroniser
// Notes: power-on reset is rstn_i itself
`timescale 1ns/10ps
module rbc_top #(
   parameter int QUAL_CYC = rbc_pkg::QUAL_CYC,
   parameter int BAD_CYC = rbc_pkg::BAD_CYC,
   parameter int RELEASE_CYC = rbc_pkg::RELEASE_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [rbc_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic ext_reset_line_i,
   input wire logic dip_below_i,
   input wire logic sleep_i,
   input wire logic halt_i,
   input wire logic clr_wdt_i,
   input wire logic wdt_ovf_i,
   output logic core_rst_o,
   output logic pc_rst_o,
   output logic port_preset_o,
   output logic pin_is_io_o,
   output logic [7:0] thr_sel_o,
   output logic irq_o
);
   import rbc_pkg::*;

   typedef struct packed {
      logic wreq;
      logic [7:0] rdata;
      logic [7:0] thr;
      logic dip_flag;
      logic bad_flag;
      logic tmo;
      logic pwrdn;
      logic [3:0] ist;
      logic [3:0] imask;
      logic pin_en;
      logic pin_s1;
      logic pin_s2;
      logic dip_s1;
      logic dip_s2;
      logic [15:0] qcnt;
      logic [15:0] bcnt;
      logic [15:0] dcnt;
      rbc_state_e st;
      logic full;
      logic core_rst;
      logic pc_rst;
      logic port_pre;
      logic pin_io;
      logic irq;
   } rbc_regs_s;

   // power-on: sequencer in release delay, full reset, port preset
   localparam rbc_regs_s RST_V = '{
      wreq: 1'b1, thr: THR_RST, pin_en: PIN_EN_RST,
      pin_s1: 1'b1, pin_s2: 1'b1, st: ST_DELAY, full: 1'b1,
      core_rst: 1'b1, pc_rst: 1'b1, port_pre: 1'b1,
      pin_io: ~PIN_EN_RST, default: '0};

   rbc_regs_s r;
   rbc_regs_s n;
   logic req;
   logic acc;
   logic wr0;
   logic pin_low;
   logic lv_en;
   logic dip_act;
   logic bad_act;
   logic wdt_ev;
   logic dip_ev;

   function automatic logic thr_known(input logic [7:0] c);
      return c inside {THR_1V9, THR_2V1, THR_3V15, THR_4V2, THR_OFF};
   endfunction : thr_known

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      n = r;
      // bus: one wait state, answer at the second edge
      req = avs_read_i | avs_write_i;
      acc = req & ~r.wreq;
      wr0 = acc & avs_write_i & avs_byteenable_i[0];
      n.wreq = ~(req & r.wreq);
      if (req & r.wreq & avs_read_i) begin
         unique case (avs_address_i)
            OFS_THR: n.rdata = r.thr;
            OFS_CAUSE: n.rdata = {5'h00, r.dip_flag, r.bad_flag, 1'b0};
            OFS_ISTAT: n.rdata = {4'h0, r.ist};
            OFS_IMASK: n.rdata = {4'h0, r.imask};
            OFS_CTRL: n.rdata = {7'h00, r.pin_en};
            OFS_FLAGS: n.rdata = {6'h00, r.tmo, r.pwrdn};
            default: n.rdata = 8'h00; // unmapped reads zero
         endcase
      end

      // software writes first, so hardware sets below win
      if (wr0) begin
         unique case (avs_address_i)
            OFS_THR: n.thr = avs_writedata_i[7:0];
            OFS_CAUSE: begin
               // write zero clears, write one leaves alone
               n.dip_flag = r.dip_flag & avs_writedata_i[BIT_DIP]; // R16
               n.bad_flag = r.bad_flag & avs_writedata_i[BIT_BAD]; // R16
            end
            OFS_ISTAT: n.ist = r.ist & ~avs_writedata_i[3:0];
            OFS_IMASK: n.imask = avs_writedata_i[3:0];
            OFS_CTRL: n.pin_en = avs_writedata_i[0];
            default: ;
         endcase
      end

      // two-stage synchronisers; stage one feeds stage two only
      n.pin_s1 = ext_reset_line_i; // R18
      n.pin_s2 = r.pin_s1;
      n.dip_s1 = dip_below_i; // R18
      n.dip_s2 = r.dip_s1;

      // pin counts only when the option picks reset function
      pin_low = r.pin_en & ~r.pin_s2; // R04

      // detection off in sleep, for disable and undefined codes
      lv_en = ~sleep_i & thr_known(r.thr) & (r.thr != THR_OFF); // R14 R09
      if (lv_en & r.dip_s2) begin
         if (r.qcnt != 16'(QUAL_CYC)) begin
            n.qcnt = r.qcnt + 16'h0001; // R07
         end
      end else begin
         n.qcnt = 16'h0000; // R08
      end
      dip_act = lv_en & r.dip_s2 & (r.qcnt == 16'(QUAL_CYC)); // R07 R08
      dip_ev = dip_act & (r.st != ST_HOLD);

      // an undefined code, noise or software, must persist to reset
      if (!thr_known(r.thr)) begin
         if (r.bcnt != 16'(BAD_CYC)) begin
            n.bcnt = r.bcnt + 16'h0001; // R10
         end
      end else begin
         n.bcnt = 16'h0000;
      end
      bad_act = r.bcnt == 16'(BAD_CYC);
      wdt_ev = wdt_ovf_i & (r.st == ST_RUN);

      // powerdown and timeout flags; set wins over the clear
      if (clr_wdt_i) begin
         n.pwrdn = 1'b0;
         n.tmo = 1'b0;
      end
      if (halt_i) begin
         n.pwrdn = 1'b1;
      end

      // reset sequencer
      if (r.st != ST_DELAY) begin
         n.dcnt = 16'h0000;
      end
      unique case (r.st)
         ST_RUN: begin
            if (pin_low | dip_act) begin
               n.st = ST_HOLD; // R02
               n.full = 1'b1;
               n.ist[EV_PIN] = r.ist[EV_PIN] | pin_low;
            end else if (bad_act) begin
               n.st = ST_DELAY; // R10
               n.full = 1'b1;
               n.bad_flag = 1'b1; // R10
               n.ist[EV_BAD] = 1'b1;
               n.thr = THR_RST; // R11
            end else if (wdt_ev) begin
               n.st = ST_DELAY; // R15
               // in sleep core and program counter reset, no port preset
               n.full = ~sleep_i;
               n.tmo = 1'b1; // R17
               n.ist[EV_WDT] = 1'b1;
            end
         end
         ST_HOLD: begin
            // no activity while the line is low or supply stays low
            if (!(pin_low | dip_act)) begin
               n.st = ST_DELAY; // R05
            end
         end
         ST_DELAY: begin
            if (pin_low | dip_act) begin
               n.st = ST_HOLD;
            end else if (r.dcnt == 16'(RELEASE_CYC - 1)) begin
               n.st = ST_RUN; // R05
            end else begin
               n.dcnt = r.dcnt + 16'h0001;
            end
         end
      endcase
      // dip reset flags the cause but keeps the threshold code
      if (dip_ev) begin
         n.dip_flag = 1'b1; // R07 R13
         n.ist[EV_DIP] = 1'b1;
      end

      // outputs registered from the next state
      n.core_rst = n.st != ST_RUN; // R02 R15
      n.pc_rst = n.st != ST_RUN; // R01 R06
      n.port_pre = n.full & (n.st != ST_RUN); // R03
      n.pin_io = ~n.pin_en; // R04
      n.irq = |(n.ist & n.imask);
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; power-on values are constants only
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r <= RST_V; // R01 R03 R12 R16 R17
      end else begin
         r <= n;
      end
   end

   // outputs straight from flip-flops
   assign avs_readdata_o = {24'h000000, r.rdata};
   assign avs_waitrequest_o = r.wreq;
   assign core_rst_o = r.core_rst;
   assign pc_rst_o = r.pc_rst;
   assign port_preset_o = r.port_pre;
   assign pin_is_io_o = r.pin_io;
   assign thr_sel_o = r.thr;
   assign irq_o = r.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   property p_bad_restore;
      (r.st == ST_RUN) && bad_act && !pin_low && !dip_act
         |=> (r.thr == THR_RST) && r.bad_flag;
   endproperty
   a_bad_restore: assert property (p_bad_restore) // R11
      else $error("threshold not restored after bad code");

   property p_bad_wait;
      !thr_known(r.thr) && (r.bcnt == 16'h0000) && (r.st == ST_RUN)
         ##1 !thr_known(r.thr) |-> !r.core_rst;
   endproperty
   a_bad_wait: assert property (p_bad_wait) // R10
      else $error("bad code reset without delay");

   property p_dip_keep;
      dip_ev |=> r.dip_flag && (r.thr == $past(r.thr));
   endproperty
   a_dip_keep: assert property (p_dip_keep) // R13
      else $error("dip reset altered threshold or missed flag");

   property p_dip_reset;
      dip_act && (r.st == ST_RUN) |=> ##1 core_rst_o;
   endproperty
   a_dip_reset: assert property (p_dip_reset) // R07
      else $error("qualified dip did not reset");

   property p_short_dip;
      !r.dip_s2 |=> (r.qcnt == 16'h0000) && !dip_ev;
   endproperty
   a_short_dip: assert property (p_short_dip) // R08
      else $error("unqualified dip raised event");

   property p_sleep_off;
      sleep_i |=> (r.qcnt == 16'h0000) && !dip_act;
   endproperty
   a_sleep_off: assert property (p_sleep_off) // R14
      else $error("dip detection active in sleep");

   property p_pin_hold;
      pin_low |=> core_rst_o && (r.st == ST_HOLD);
   endproperty
   a_pin_hold: assert property (p_pin_hold) // R05
      else $error("pin low without hold");

   property p_wdt;
      wdt_ev && !pin_low && !dip_act && !bad_act
         |=> r.tmo && pc_rst_o;
   endproperty
   a_wdt: assert property (p_wdt) // R17
      else $error("watchdog reset missed");

   property p_flag_keep;
      r.dip_flag && !wr0 |=> r.dip_flag;
   endproperty
   a_flag_keep: assert property (p_flag_keep) // R16
      else $error("dip cause flag lost without write");

   property p_pc;
      (r.st != ST_RUN) |-> pc_rst_o && core_rst_o;
   endproperty
   a_pc: assert property (p_pc) // R06
      else $error("program counter not held during reset");

   // watchdog in sleep resets program counter and core, ports untouched
   property p_wdt_sleep;
      wdt_ev && sleep_i && !pin_low && !bad_act
         |=> pc_rst_o && !port_preset_o;
   endproperty
   a_wdt_sleep: assert property (p_wdt_sleep) // R17
      else $error("watchdog in sleep gave a full reset");

   property p_wdt_full;
      wdt_ev && !sleep_i |=> core_rst_o && port_preset_o;
   endproperty
   a_wdt_full: assert property (p_wdt_full) // R15
      else $error("watchdog overflow did not reset the core");

   property p_pin_io;
      pin_is_io_o && (r.st == ST_RUN) && !dip_act |=> (r.st != ST_HOLD);
   endproperty
   a_pin_io: assert property (p_pin_io) // R04
      else $error("plain io pin caused a reset hold");

   property p_release;
      (r.st == ST_HOLD) |=> (r.st != ST_RUN);
   endproperty
   a_release: assert property (p_release) // R05
      else $error("run resumed without release delay");

   property p_off_code;
      (r.thr == THR_OFF) |=> (r.qcnt == 16'h0000);
   endproperty
   a_off_code: assert property (p_off_code) // R09
      else $error("dip qualified with detection disabled");

   property p_known_ok;
      thr_known(r.thr) |=> !bad_act;
   endproperty
   a_known_ok: assert property (p_known_ok) // R09
      else $error("defined code treated as bad setting");

   property p_bad_count;
      !thr_known(r.thr) |=> (r.bcnt != 16'h0000);
   endproperty
   a_bad_count: assert property (p_bad_count) // R10
      else $error("bad code delay not running");

   property p_bad_keep;
      r.bad_flag && !wr0 |=> r.bad_flag;
   endproperty
   a_bad_keep: assert property (p_bad_keep) // R16
      else $error("bad setting flag lost without write");

   property p_tmo_keep;
      r.tmo && !clr_wdt_i |=> r.tmo;
   endproperty
   a_tmo_keep: assert property (p_tmo_keep) // R17
      else $error("timeout flag lost without clear");

   property p_pwrdn_set;
      halt_i |=> r.pwrdn;
   endproperty
   a_pwrdn_set: assert property (p_pwrdn_set) // R17
      else $error("halt did not set powerdown flag");

   // bus contract: exactly one wait state, low for one cycle only
   property p_wait_one;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("bus request not answered after one wait state");

   property p_wait_back;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_back: assert property (p_wait_back)
      else $error("waitrequest low for more than one cycle");

   c_pin: cover property (pin_low ##1 r.st == ST_HOLD);
   c_dip: cover property (dip_ev);
   c_bad: cover property ((r.st == ST_RUN) && bad_act);
   c_wdt_sleep: cover property (wdt_ev && sleep_i);
   c_short_dip: cover property ((r.qcnt != 16'h0000) && !r.dip_s2);
endmodule : rbc_top

// *** shared/rbc_pkg.sv ***
// Purpose: constants and types of the reset and brownout control block
// Assumes: 40 MHz system clock, Avalon-MM register slave
// Notes: delays run on the system clock, figures given in ns
//
// Overview of operation
// (R01) power-on reset clears the program counter to zero
// (R02) low external reset line gives a normal-operation reset until high
// (R03) power-on reset presets port data and direction to all ones
// (R04) external reset line acts as reset only when option selects it
// (R05) after line release wait the pin release delay; hold while low
// (R06) every reset returns the program counter to zero
// (R07) supply low longer than qualify time resets and sets dip flag
// (R08) supply dips no longer than qualify time are ignored
// (R09) decode threshold codes 66, 55, 33, 99 and f0 as disable
// (R10) any other code resets after bad-setting delay and sets its flag
// (R11) bad-setting reset restores threshold register to power-on value
// (R12) threshold register powers up holding 66
// (R13) supply dip reset leaves the threshold register unchanged
// (R14) dip detection is forced off in idle or sleep modes; the code forces it off with sleep_i only
// (R15) watchdog overflow resets the microcontroller
// (R16) cause flags set by hardware only, cleared by software zero only
// (R17) power-on clears timeout and powerdown flags; watchdog sets timeout
// (R18) external line and comparator synchronised before qualification
package rbc_pkg;
   localparam int ADDR_W = 5;
   // register byte offsets
   localparam logic [4:0] OFS_THR = 5'h00;
   localparam logic [4:0] OFS_CAUSE = 5'h04;
   localparam logic [4:0] OFS_ISTAT = 5'h08;
   localparam logic [4:0] OFS_IMASK = 5'h0c;
   localparam logic [4:0] OFS_CTRL = 5'h10;
   localparam logic [4:0] OFS_FLAGS = 5'h14;
   // cause register bits
   localparam int BIT_BAD = 1;
   localparam int BIT_DIP = 2;
   // interrupt status bits
   localparam int EV_PIN = 0;
   localparam int EV_DIP = 1;
   localparam int EV_BAD = 2;
   localparam int EV_WDT = 3;
   // flags register bits
   localparam int BIT_PWRDN = 0;
   localparam int BIT_TMO = 1;
   // threshold codes
   localparam logic [7:0] THR_1V9 = 8'h66;
   localparam logic [7:0] THR_2V1 = 8'h55;
   localparam logic [7:0] THR_3V15 = 8'h33;
   localparam logic [7:0] THR_4V2 = 8'h99;
   localparam logic [7:0] THR_OFF = 8'hf0;
   localparam logic [7:0] THR_RST = THR_1V9;
   localparam logic PIN_EN_RST = 1'b1;
   // timing
   localparam int CLK_NS = 25;
   localparam int QUAL_NS = 60000;
   localparam int BAD_NS = 100000;
   localparam int RELEASE_NS = 1000000;
   localparam int QUAL_CYC = (QUAL_NS + CLK_NS - 1) / CLK_NS;
   localparam int BAD_CYC = (BAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int RELEASE_CYC = (RELEASE_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_DELAY} rbc_state_e;
endpackage : rbc_pkg

// *** tb/rbc_board_model.sv ***
// Purpose: board side of the block, reset network and supply monitor
// Assumes: driven from the bench through the two tasks below
// Notes: a pull-up holds the reset line high while nobody pulls it
`timescale 1ns/10ps
module rbc_board_model (
   input wire logic sys_clk_i,
   output logic ext_reset_line_o,
   output logic dip_below_o
);
   // released line and healthy supply at power-up
   initial begin
      ext_reset_line_o = 1'b1;
      dip_below_o = 1'b0;
   end
   //////////////////////////////
   // rc network or button holds the line low for n cycles
   task automatic pull(input int n);
      @(posedge sys_clk_i);
      ext_reset_line_o <= 1'b0;
      repeat (n) @(posedge sys_clk_i);
      ext_reset_line_o <= 1'b1; // pull-up, never left floating
   endtask : pull
   // comparator reports a supply below threshold for n cycles
   task automatic dip(input int n);
      @(posedge sys_clk_i);
      dip_below_o <= 1'b1;
      repeat (n) @(posedge sys_clk_i);
      dip_below_o <= 1'b0;
   endtask : dip
endmodule : rbc_board_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the reset and brownout control
// Assumes: delays shrunk to 4, 6 and 8 cycles by parameter
// Notes: bus tasks wait on waitrequest, never on a fixed count
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
   bad_count++; $display("Error %s expected %h seen %h", n, e, a); end end
module tb_top;
   import rbc_pkg::*;
   logic sys_clk = 1'b0;
   // bench-driven inputs, given idle values at time zero below
   logic rstn, rd, wr, sleep, halt, clrw, wdt;
   logic [4:0] addr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic [31:0] rdata;
   logic wreq, line, dip, core, pc, preset, isio, irq, ok;
   logic [7:0] thr, q;
   int bad_count = 0;
   int n_compared = 0;
   // 40 MHz system clock
   always #12.5 sys_clk = ~sys_clk;
   rbc_top #(.QUAL_CYC(4), .BAD_CYC(6), .RELEASE_CYC(8)) DUT (
      .sys_clk_i(sys_clk), .rstn_i(rstn), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .ext_reset_line_i(line),
      .dip_below_i(dip), .sleep_i(sleep), .halt_i(halt),
      .clr_wdt_i(clrw), .wdt_ovf_i(wdt), .core_rst_o(core),
      .pc_rst_o(pc), .port_preset_o(preset), .pin_is_io_o(isio),
      .thr_sel_o(thr), .irq_o(irq));
   rbc_board_model board (.sys_clk_i(sys_clk),
      .ext_reset_line_o(line), .dip_below_o(dip));
   //////////////////////////////
   // one access; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a,
      input logic [7:0] d, output logic [7:0] r);
      @(posedge sys_clk);
      wr <= w;
      rd <= ~w;
      addr <= a;
      wdata <= {24'h0, d};
      // only the bench watchdog ends a hung wait
      do begin
         @(posedge sys_clk);
      end while (wreq !== 1'b0);
      r = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   // bounded wait for core reset (s=0) or pc reset (s=1) to reach v
   task automatic waitr(input logic s, input logic v, output logic f);
      f = 1'b0;
      for (int i = 0; i < 60 && !f; i++) begin
         @(posedge sys_clk);
         f = ((s ? pc : core) === v);
      end
   endtask : waitr
   task automatic print_verdict;
      if (bad_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   //////////////////////////////
   task automatic t_power_on;
      repeat (12) @(posedge sys_clk);
      `CHK("pc_rst", 1'b1, pc)
      `CHK("preset", 1'b1, preset)
      rstn <= 1'b1;
      waitr(0, 0, ok);
      `CHK("release", 1'b1, ok)
      `CHK("thr_sel", THR_RST, thr)
      `CHK("pin_io", 1'b0, isio)
      bus(0, OFS_THR, 8'h00, q);
      `CHK("thr", THR_RST, q)
      bus(0, OFS_FLAGS, 8'h00, q);
      `CHK("flags", 8'h00, q)
   endtask : t_power_on
   task automatic t_codes;
      logic [7:0] c [5] = '{THR_1V9, THR_2V1, THR_3V15, THR_4V2, THR_OFF};
      foreach (c[i]) begin
         bus(1, OFS_THR, c[i], q);
         bus(0, OFS_THR, 8'h00, q);
         `CHK("thr", c[i], q)
         `CHK("thr_sel", c[i], thr)
      end
      // low byte lane disabled: the write must be dropped
      be <= 4'he;
      bus(1, OFS_THR, THR_2V1, q);
      be <= 4'hf;
      bus(0, OFS_THR, 8'h00, q);
      `CHK("thr_be", THR_OFF, q)
      // detection is off with the disable code
      board.dip(12);
      waitr(0, 1, ok);
      `CHK("off_dip", 1'b0, ok)
      bus(1, 5'h1c, 8'h5a, q);
      bus(0, 5'h1c, 8'h00, q);
      `CHK("unmapped", 8'h00, q)
   endtask : t_codes
   task automatic t_dip;
      bus(1, OFS_THR, THR_2V1, q);
      board.dip(3);
      waitr(0, 1, ok);
      `CHK("short_dip", 1'b0, ok)
      bus(1, OFS_ISTAT, 8'h0f, q);
      bus(1, OFS_IMASK, 8'h02, q);
      board.dip(12);
      waitr(0, 1, ok);
      `CHK("dip_rst", 1'b1, ok)
      waitr(0, 0, ok);
      `CHK("thr_kept", THR_2V1, thr)
      bus(0, OFS_CAUSE, 8'h00, q);
      `CHK("cause", 8'h04, q)
      `CHK("irq", 1'b1, irq)
      bus(1, OFS_ISTAT, 8'h02, q);
      repeat (2) @(posedge sys_clk);
      `CHK("irq_clr", 1'b0, irq)
      @(posedge sys_clk);
      sleep <= 1'b1;
      board.dip(12);
      waitr(0, 1, ok);
      `CHK("sleep_dip", 1'b0, ok)
      sleep <= 1'b0;
   endtask : t_dip
   task automatic t_bad;
      bus(1, OFS_THR, 8'h12, q);
      waitr(0, 1, ok);
      `CHK("bad_rst", 1'b1, ok)
      waitr(0, 0, ok);
      `CHK("thr_back", THR_RST, thr)
      bus(0, OFS_CAUSE, 8'h00, q);
      `CHK("cause", 8'h06, q)
      bus(1, OFS_CAUSE, 8'h00, q);
      bus(0, OFS_CAUSE, 8'h00, q);
      `CHK("cause_clr", 8'h00, q)
   endtask : t_bad
   task automatic t_pin;
      fork
         board.pull(20);
         begin
            repeat (16) @(posedge sys_clk);
            `CHK("hold", 1'b1, core)
            `CHK("pc_hold", 1'b1, pc)
         end
      join
      repeat (4) @(posedge sys_clk);
      `CHK("extra", 1'b1, core)
      waitr(0, 0, ok);
      `CHK("restart", 1'b1, ok)
      bus(1, OFS_CTRL, 8'h00, q);
      @(posedge sys_clk);
      `CHK("pin_io", 1'b1, isio)
      board.pull(20);
      waitr(0, 1, ok);
      `CHK("io_pin", 1'b0, ok)
      bus(1, OFS_CTRL, 8'h01, q);
   endtask : t_pin
   task automatic t_wdt;
      @(posedge sys_clk);
      wdt <= 1'b1;
      @(posedge sys_clk);
      wdt <= 1'b0;
      waitr(1, 1, ok);
      `CHK("wdt_rst", 1'b1, ok)
      `CHK("preset", 1'b1, preset)
      waitr(0, 0, ok);
      bus(0, OFS_FLAGS, 8'h00, q);
      `CHK("flags", 8'h02, q)
      halt <= 1'b1;
      @(posedge sys_clk);
      halt <= 1'b0;
      sleep <= 1'b1;
      wdt <= 1'b1;
      @(posedge sys_clk);
      wdt <= 1'b0;
      waitr(1, 1, ok);
      `CHK("pc_sleep", 1'b1, ok)
      `CHK("no_preset", 1'b0, preset)
      waitr(1, 0, ok);
      sleep <= 1'b0;
      bus(0, OFS_FLAGS, 8'h00, q);
      `CHK("flags", 8'h03, q)
      clrw <= 1'b1;
      @(posedge sys_clk);
      clrw <= 1'b0;
      bus(0, OFS_FLAGS, 8'h00, q);
      `CHK("flags_clr", 8'h00, q)
   endtask : t_wdt
   // main sequence, inputs idle and reset asserted from time zero
   initial begin
      rstn <= 1'b0;
      addr <= 5'h00;
      rd <= 1'b0;
      wr <= 1'b0;
      wdata <= 32'h0;
      be <= 4'hf;
      sleep <= 1'b0;
      halt <= 1'b0;
      clrw <= 1'b0;
      wdt <= 1'b0;
      t_power_on;
      t_codes;
      t_dip;
      t_bad;
      t_pin;
      t_wdt;
      print_verdict;
   end
   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      #(25 * 20000);
      bad_count++;
      print_verdict;
   end
endmodule : tb_top
